// file: design/vcsp_pkg.sv
// Purpose: Constants, carriers and code conversion for the voice codec serial port
// Assumes: 13-bit two's complement samples on the converter side
// Notes: The companding law here is a generic 8-segment law
package vcsp_pkg;
	localparam int unsigned VCSP_SAMPLE_W = 13;
	localparam int unsigned VCSP_CTRL_W = 3;
	localparam logic [4:0] VCSP_LIN_LEN = 5'h10;
	localparam logic [4:0] VCSP_CMP_LEN = 5'h08;
	localparam logic [4:0] VCSP_PAD_FIRST = 5'h0e;
	localparam int unsigned VCSP_STANDBY_FRAMES = 5;
	localparam int unsigned VCSP_FRAME_BITS_DEF = 256;
	localparam int unsigned VCSP_FIXED_DETECT_DEF = 256;
	// Register byte offsets
	localparam logic [3:0] VCSP_OFS_TX_DATA = 4'h0;
	localparam logic [3:0] VCSP_OFS_RX_DATA = 4'h4;
	localparam logic [3:0] VCSP_OFS_STATUS = 4'h8;
	// Field positions
	localparam int unsigned VCSP_RX_VOL_POS = 16;
	localparam int unsigned VCSP_RX_NEW_POS = 31;
	localparam int unsigned VCSP_ST_FIXED_POS = 0;
	localparam int unsigned VCSP_ST_LINEAR_POS = 1;
	localparam int unsigned VCSP_ST_TXSB_POS = 2;
	localparam int unsigned VCSP_ST_RXSB_POS = 3;
	localparam int unsigned VCSP_ST_TXBUSY_POS = 4;
	// Reset values
	localparam logic [2:0] VCSP_VOL_RST = 3'h0;
	localparam logic [12:0] VCSP_SAMPLE_RST = 13'h0000;

	typedef struct packed {
		logic [2:0] volume;
		logic [12:0] sample;
	} vcsp_rx_word_t;

	typedef struct packed {
		logic rx_bit_clock_select;
		logic dclkx;
		logic tx_frame_sync;
		logic rx_frame_sync;
		logic din;
		logic lin_sel;
		logic req;
	} vcsp_pins_t;

	typedef struct packed {
		logic fixed;
		logic linear;
		logic tx_sb;
		logic rx_sb;
	} vcsp_status_t;

	// Sign, 3-bit segment, 4-bit mantissa
	function automatic logic [7:0] vcsp_compress(input logic [12:0] s);
		logic [11:0] mag;
		logic [2:0] seg;
		logic [3:0] mant;
		mag = s[12] ? ~s[11:0] : s[11:0];
		seg = 3'h0;
		mant = mag[4:1];
		for (int i = 1; i < 8; i++) begin
			if (mag[i+4]) begin
				seg = 3'(i);
				mant = mag[i+3 -: 4];
			end
		end
		return {s[12], seg, mant};
	endfunction : vcsp_compress

	// Rebuilds mid-step magnitude of each segment
	function automatic logic [12:0] vcsp_expand(input logic [7:0] c);
		logic [11:0] mag;
		if (c[6:4] == 3'h0) begin
			mag = 12'({c[3:0], 1'b1});
		end else begin
			mag = 12'({1'b1, c[3:0], 1'b1}) << (c[6:4] - 3'h1);
		end
		return c[7] ? {1'b1, ~mag} : {1'b0, mag};
	endfunction : vcsp_expand
endpackage : vcsp_pkg

// file: design/vcsp_top.sv
// Purpose: Serial data port of a voice codec with an Avalon-MM register slave
// Assumes: Link pins are asynchronous to i_clk_sys; i_clk_link is the master clock
// Notes: Variable-rate data clocks must be well below the master clock rate
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module vcsp_top import vcsp_pkg::*; #(
	parameter int unsigned FRAME_BITS = VCSP_FRAME_BITS_DEF,
	parameter int unsigned FIXED_DETECT = VCSP_FIXED_DETECT_DEF
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [2:0] o_volume_setting,
	input wire logic i_clk_link,
	input wire logic i_rx_bit_clock_select,
	input wire logic i_tx_bit_clock,
	input wire logic i_tx_frame_sync,
	input wire logic i_rx_frame_sync,
	input wire logic i_linear_format_select,
	input wire logic i_rx_data,
	output logic o_tx_data,
	output logic o_tx_data_oe
);
	localparam int unsigned SB_MAX = VCSP_STANDBY_FRAMES * FRAME_BITS;
	localparam int unsigned SB_W = $clog2(SB_MAX + 1);
	localparam int unsigned FIX_W = $clog2(FIXED_DETECT);
	typedef enum logic {VCSP_TX_IDLE, VCSP_TX_SHIFT} vcsp_tx_st_t;
	typedef enum logic {VCSP_RX_IDLE, VCSP_RX_SHIFT} vcsp_rx_st_t;

	// System-domain state
	logic [12:0] tx_sample_r, tx_sample_nxt;
	logic tx_req_r, tx_req_nxt;
	logic ack_s1_r, ack_s2_r, tgl_s1_r, tgl_s2_r, tgl_s3_r;
	vcsp_status_t st_s1_r, st_s2_r;
	vcsp_rx_word_t rx_data_r, rx_data_nxt;
	logic rx_new_r, rx_new_nxt, rd_done_r, rd_done_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic tx_busy;
	// Link-domain state
	logic [1:0] lnk_nrst_r;
	vcsp_pins_t ps1_r, ps2_r, ps3_r;
	logic din_n_r, fsx_n_r, fsr_n_r;
	logic [FIX_W-1:0] fix_cnt_r, fix_cnt_nxt;
	logic fixed_r, fixed_nxt;
	logic [12:0] tx_hold_r, tx_hold_nxt;
	logic ack_r, ack_nxt, rx_tgl_r, rx_tgl_nxt;
	vcsp_rx_word_t rx_word_r, rx_word_nxt;
	vcsp_tx_st_t tx_st_r, tx_st_nxt;
	vcsp_rx_st_t rx_st_r, rx_st_nxt;
	logic [15:0] tx_sr_r, tx_sr_nxt, rx_sr_r, rx_sr_nxt, tx_word;
	logic [4:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt, word_len;
	logic dout_nxt, oe_nxt, tx_fsp_r, tx_fsp_nxt, rx_fsp_r, rx_fsp_nxt;
	logic [SB_W-1:0] tx_sb_r, tx_sb_nxt, rx_sb_r, rx_sb_nxt;
	logic linear, tx_evt, rx_evt, tx_fs, rx_fs, rx_bit, rx_done;
	logic [7:0] oe_run_r;

	// Sender busy until the link echoes the request toggle
	assign tx_busy = tx_req_r ^ ack_s2_r;
	assign o_avs_waitrequest = (i_avs_read && !rd_done_r) ||
		(i_avs_write && i_avs_address == VCSP_OFS_TX_DATA && tx_busy);
	assign o_avs_readdata = rdata_r;
	assign o_volume_setting = rx_data_r.volume;

	// Bus slave: reads answer one cycle late so data come from a flop
	always_comb begin
		tx_sample_nxt = tx_sample_r;
		tx_req_nxt = tx_req_r;
		rx_data_nxt = rx_data_r;
		rx_new_nxt = rx_new_r;
		rdata_nxt = rdata_r;
		rd_done_nxt = i_avs_read && !rd_done_r;
		if (i_avs_write && !o_avs_waitrequest && i_avs_address == VCSP_OFS_TX_DATA) begin
			tx_sample_nxt = i_avs_writedata[12:0];
			tx_req_nxt = !tx_req_r;
		end
		if (i_avs_read && !rd_done_r) begin
			rdata_nxt = 32'h0000_0000;
			unique case (i_avs_address)
				VCSP_OFS_TX_DATA: rdata_nxt[12:0] = tx_sample_r;
				VCSP_OFS_RX_DATA: begin
					rdata_nxt[12:0] = rx_data_r.sample;
					rdata_nxt[VCSP_RX_VOL_POS +: 3] = rx_data_r.volume;
					rdata_nxt[VCSP_RX_NEW_POS] = rx_new_r;
					rx_new_nxt = 1'b0;
				end
				VCSP_OFS_STATUS: begin
					rdata_nxt[VCSP_ST_FIXED_POS] = st_s2_r.fixed;
					rdata_nxt[VCSP_ST_LINEAR_POS] = st_s2_r.linear;
					rdata_nxt[VCSP_ST_TXSB_POS] = st_s2_r.tx_sb;
					rdata_nxt[VCSP_ST_RXSB_POS] = st_s2_r.rx_sb;
					rdata_nxt[VCSP_ST_TXBUSY_POS] = tx_busy;
				end
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		// New received word wins over the read clear
		if (tgl_s2_r ^ tgl_s3_r) begin
			rx_data_nxt = rx_word_r;
			rx_new_nxt = 1'b1;
		end
	end

	// System registers and crossing flops
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_sample_r <= VCSP_SAMPLE_RST;
			tx_req_r <= 1'b0;
			rx_data_r <= '{volume: VCSP_VOL_RST, sample: VCSP_SAMPLE_RST};
			rx_new_r <= 1'b0;
			rd_done_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			{ack_s1_r, ack_s2_r, tgl_s1_r, tgl_s2_r, tgl_s3_r} <= 5'h00;
			st_s1_r <= '0;
			st_s2_r <= '0;
		end else begin
			tx_sample_r <= tx_sample_nxt;
			tx_req_r <= tx_req_nxt;
			rx_data_r <= rx_data_nxt;
			rx_new_r <= rx_new_nxt;
			rd_done_r <= rd_done_nxt;
			rdata_r <= rdata_nxt;
			{ack_s1_r, ack_s2_r} <= {ack_r, ack_s1_r};
			{tgl_s1_r, tgl_s2_r, tgl_s3_r} <= {rx_tgl_r, tgl_s1_r, tgl_s2_r};
			st_s1_r <= '{fixed: fixed_r, linear: linear, tx_sb: tx_sb_r == SB_W'(SB_MAX),
				rx_sb: rx_sb_r == SB_W'(SB_MAX)};
			st_s2_r <= st_s1_r;
		end
	end

	// Link reset: asserts at once, releases on the link clock
	always_ff @(posedge i_clk_link or negedge i_nrst) begin
		if (!i_nrst) begin
			lnk_nrst_r <= 2'h0;
		end else begin
			lnk_nrst_r <= {lnk_nrst_r[0], 1'b1};
		end
	end

	// Fixed rate: pins are synchronous to the master clock, taken on its fall
	always_ff @(negedge i_clk_link or negedge lnk_nrst_r[1]) begin
		if (!lnk_nrst_r[1]) begin
			{din_n_r, fsx_n_r, fsr_n_r} <= 3'h0;
		end else begin
			{din_n_r, fsx_n_r, fsr_n_r} <= {i_rx_data, i_tx_frame_sync, i_rx_frame_sync};
		end
	end

	// Bit events; all pins share one sync depth so their relation holds
	always_comb begin
		linear = !ps2_r.lin_sel;
		word_len = linear ? VCSP_LIN_LEN : VCSP_CMP_LEN;
		tx_evt = fixed_r || (ps2_r.dclkx && !ps3_r.dclkx);
		rx_evt = fixed_r || (!ps2_r.rx_bit_clock_select && ps3_r.rx_bit_clock_select);
		tx_fs = fixed_r ? fsx_n_r : ps2_r.tx_frame_sync;
		rx_fs = fixed_r ? fsr_n_r : ps2_r.rx_frame_sync;
		rx_bit = fixed_r ? din_n_r : ps2_r.din;
		// Companded code sits left-aligned; linear pads three zeros
		tx_word = linear ? {tx_hold_r, 3'h0} : {vcsp_compress(tx_hold_r), 8'h00};
		fix_cnt_nxt = fix_cnt_r;
		fixed_nxt = fixed_r;
		// A toggling clock never stays high long enough to look tied
		if (!ps2_r.rx_bit_clock_select) begin
			fix_cnt_nxt = '0;
			fixed_nxt = 1'b0;
		end else if (fix_cnt_r == FIX_W'(FIXED_DETECT - 1)) begin
			fixed_nxt = 1'b1;
		end else begin
			fix_cnt_nxt = fix_cnt_r + 1'b1;
		end
		tx_hold_nxt = tx_hold_r;
		ack_nxt = ack_r;
		if (ps2_r.req ^ ps3_r.req) begin
			tx_hold_nxt = tx_sample_r;
			ack_nxt = ps2_r.req;
		end
	end

	// Transmit shifter
	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_sr_nxt = tx_sr_r;
		tx_cnt_nxt = tx_cnt_r;
		dout_nxt = o_tx_data;
		oe_nxt = o_tx_data_oe;
		tx_fsp_nxt = tx_fsp_r;
		tx_sb_nxt = tx_sb_r;
		if (tx_evt) begin
			tx_fsp_nxt = tx_fs;
			if (tx_fs) begin
				tx_sb_nxt = '0;
			end else if (tx_sb_r != SB_W'(SB_MAX)) begin
				tx_sb_nxt = tx_sb_r + 1'b1;
			end
			unique case (tx_st_r)
				VCSP_TX_IDLE: begin
					if (tx_fs && !tx_fsp_r) begin
						dout_nxt = tx_word[15];
						tx_sr_nxt = {tx_word[14:0], 1'b0};
						oe_nxt = 1'b1;
						tx_cnt_nxt = 5'h01;
						tx_st_nxt = VCSP_TX_SHIFT;
					end
				end
				VCSP_TX_SHIFT: begin
					if (tx_cnt_r == word_len) begin
						dout_nxt = 1'b0;
						oe_nxt = 1'b0;
						tx_st_nxt = VCSP_TX_IDLE;
					end else begin
						dout_nxt = tx_sr_r[15];
						tx_sr_nxt = {tx_sr_r[14:0], 1'b0};
						tx_cnt_nxt = tx_cnt_r + 1'b1;
					end
				end
			endcase
		end
	end

	// Receive shifter and decoder
	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_sr_nxt = rx_sr_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_fsp_nxt = rx_fsp_r;
		rx_sb_nxt = rx_sb_r;
		rx_word_nxt = rx_word_r;
		rx_tgl_nxt = rx_tgl_r;
		rx_done = 1'b0;
		if (rx_evt) begin
			rx_fsp_nxt = rx_fs;
			if (rx_fs) begin
				rx_sb_nxt = '0;
			end else if (rx_sb_r != SB_W'(SB_MAX)) begin
				rx_sb_nxt = rx_sb_r + 1'b1;
			end
			unique case (rx_st_r)
				VCSP_RX_IDLE: begin
					if (rx_fs && !rx_fsp_r) begin
						rx_sr_nxt = {rx_sr_r[14:0], rx_bit};
						rx_cnt_nxt = 5'h01;
						rx_st_nxt = VCSP_RX_SHIFT;
					end
				end
				VCSP_RX_SHIFT: begin
					rx_sr_nxt = {rx_sr_r[14:0], rx_bit};
					rx_cnt_nxt = rx_cnt_r + 1'b1;
					if (rx_cnt_nxt == word_len) begin
						rx_done = 1'b1;
						rx_st_nxt = VCSP_RX_IDLE;
					end
				end
			endcase
		end
		if (rx_done) begin
			rx_tgl_nxt = !rx_tgl_r;
			if (linear) begin
				rx_word_nxt = '{volume: rx_sr_nxt[2:0], sample: rx_sr_nxt[15:3]};
			end else begin
				rx_word_nxt.sample = vcsp_expand(rx_sr_nxt[7:0]);
			end
		end
	end

	// Link registers; launch on the rising master clock
	always_ff @(posedge i_clk_link or negedge lnk_nrst_r[1]) begin
		if (!lnk_nrst_r[1]) begin
			ps1_r <= '0;
			ps2_r <= '0;
			ps3_r <= '0;
			fix_cnt_r <= '0;
			fixed_r <= 1'b0;
			tx_hold_r <= VCSP_SAMPLE_RST;
			ack_r <= 1'b0;
			tx_st_r <= VCSP_TX_IDLE;
			tx_sr_r <= 16'h0000;
			tx_cnt_r <= 5'h00;
			o_tx_data <= 1'b0;
			o_tx_data_oe <= 1'b0;
			tx_fsp_r <= 1'b0;
			tx_sb_r <= '0;
			rx_st_r <= VCSP_RX_IDLE;
			rx_sr_r <= 16'h0000;
			rx_cnt_r <= 5'h00;
			rx_fsp_r <= 1'b0;
			rx_sb_r <= '0;
			rx_word_r <= '{volume: VCSP_VOL_RST, sample: VCSP_SAMPLE_RST};
			rx_tgl_r <= 1'b0;
			oe_run_r <= 8'h00;
		end else begin
			ps1_r <= '{rx_bit_clock_select: i_rx_bit_clock_select, dclkx: i_tx_bit_clock, tx_frame_sync: i_tx_frame_sync,
				rx_frame_sync: i_rx_frame_sync, din: i_rx_data, lin_sel: i_linear_format_select,
				req: tx_req_r};
			ps2_r <= ps1_r;
			ps3_r <= ps2_r;
			fix_cnt_r <= fix_cnt_nxt;
			fixed_r <= fixed_nxt;
			tx_hold_r <= tx_hold_nxt;
			ack_r <= ack_nxt;
			tx_st_r <= tx_st_nxt;
			tx_sr_r <= tx_sr_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			o_tx_data <= dout_nxt;
			o_tx_data_oe <= oe_nxt;
			tx_fsp_r <= tx_fsp_nxt;
			tx_sb_r <= tx_sb_nxt;
			rx_st_r <= rx_st_nxt;
			rx_sr_r <= rx_sr_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_fsp_r <= rx_fsp_nxt;
			rx_sb_r <= rx_sb_nxt;
			rx_word_r <= rx_word_nxt;
			rx_tgl_r <= rx_tgl_nxt;
			oe_run_r <= o_tx_data_oe ? oe_run_r + 8'h01 : 8'h00;
		end
	end

	sequence s_oe_eight;
		o_tx_data_oe[*8] ##1 !o_tx_data_oe;
	endsequence

	a_cmp_word_len: assert property (@(posedge i_clk_link) disable iff (!lnk_nrst_r[1])
		fixed_r && !linear && $rose(o_tx_data_oe) |-> s_oe_eight)
		else $error("companded word not eight bits");
	a_lin_word_len: assert property (@(posedge i_clk_link) disable iff (!lnk_nrst_r[1])
		fixed_r && linear && $fell(o_tx_data_oe) |-> oe_run_r == 8'h10)
		else $error("linear word not sixteen bits");
	a_lin_pad_zero: assert property (@(posedge i_clk_link) disable iff (!lnk_nrst_r[1])
		o_tx_data_oe && linear && tx_cnt_r >= VCSP_PAD_FIRST |-> !o_tx_data)
		else $error("linear padding bit not zero");
	a_tx_msb_first: assert property (@(posedge i_clk_link) disable iff (!lnk_nrst_r[1])
		$rose(o_tx_data_oe) |-> o_tx_data == $past(tx_word[15]))
		else $error("first transmit bit not word msb");
	a_vol_linear: assert property (@(posedge i_clk_link) disable iff (!lnk_nrst_r[1])
		rx_done && linear |=> rx_word_r.volume == $past(rx_sr_nxt[2:0]))
		else $error("volume not taken from control bits");
	a_vol_cmp_hold: assert property (@(posedge i_clk_link) disable iff (!lnk_nrst_r[1])
		rx_done && !linear |=> $stable(rx_word_r.volume))
		else $error("volume changed in companded format");
	a_variable_sel: assert property (@(posedge i_clk_link) disable iff (!lnk_nrst_r[1])
		!ps2_r.rx_bit_clock_select |=> !fixed_r)
		else $error("fixed rate kept with a low receive clock pin");
	a_tx_standby_exit: assert property (@(posedge i_clk_link) disable iff (!lnk_nrst_r[1])
		tx_evt && tx_fs |=> tx_sb_r == '0)
		else $error("transmit standby kept with frame sync high");
	a_rd_one_wait: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("read answer not one cycle late");
endmodule : vcsp_top

// file: verification/vcsp_dsp_model.sv
// Purpose: Far-side serial port model for the voice codec serial port, both data rates
// Assumes: Syncs and data change on rising master edges; variable rate uses a slow bit clock
// Notes: Data line shows the inverse of its last bit between frames, no pull
`timescale 1ns/1ps
module vcsp_dsp_model (
	input wire logic i_clk_link,
	input wire logic i_var_rate,
	input wire logic i_tx_data,
	input wire logic i_tx_data_oe,
	output logic o_rx_bit_clock_select,
	output logic o_tx_bit_clock,
	output logic o_tx_frame_sync,
	output logic o_rx_frame_sync,
	output logic o_rx_data
);
	// Frame period in master cycles at variable rate: 62.5 us here, so never above 16 kHz
	localparam int FRAME_MIN = 500;
	logic [15:0] tx_cap;
	logic bclk;
	int oe_miss;

	// Tied high selects fixed rate; otherwise one slow clock serves both directions
	assign o_rx_bit_clock_select = i_var_rate ? bclk : 1'b1;
	assign o_tx_bit_clock = i_var_rate ? bclk : i_clk_link;

	initial begin
		bclk = 1'b0;
		o_tx_frame_sync = 1'b0;
		o_rx_frame_sync = 1'b0;
		o_rx_data = 1'b0;
		tx_cap = 16'h0000;
		oe_miss = 0;
	end

	// One frame: gap idle cycles, sync rise with the msb, then len bits each way
	task automatic frame(input logic [15:0] w, input int len, input int gap);
		repeat (gap) @(posedge i_clk_link);
		@(posedge i_clk_link);
		o_tx_frame_sync <= 1'b1;
		o_rx_frame_sync <= 1'b1;
		o_rx_data <= w[len-1];
		tx_cap = 16'h0000;
		oe_miss = 0;
		for (int i = 0; i < len; i++) begin
			if (i_var_rate) begin
				// Device launches 2-3 master cycles after the rise, samples at the fall
				repeat (4) @(posedge i_clk_link);
				bclk <= 1'b1;
				o_rx_data <= w[len-1-i];
				repeat (4) @(posedge i_clk_link);
				bclk <= 1'b0;
			end else begin
				// Next bit launched on the rise, so it is settled at the fall
				@(posedge i_clk_link);
				if (i + 1 < len) begin
					o_rx_data <= w[len-2-i];
				end
				@(negedge i_clk_link);
			end
			tx_cap = {tx_cap[14:0], i_tx_data};
			if (i_tx_data_oe !== 1'b1) begin
				oe_miss++;
			end
		end
		if (i_var_rate) begin
			repeat (4) @(posedge i_clk_link);
		end else begin
			@(posedge i_clk_link);
		end
		o_tx_frame_sync <= 1'b0;
		o_rx_frame_sync <= 1'b0;
		o_rx_data <= ~w[0];
		// One trailing bit clock lets the device close its word; then keep the frame rate
		if (i_var_rate) begin
			repeat (4) @(posedge i_clk_link);
			bclk <= 1'b1;
			repeat (4) @(posedge i_clk_link);
			bclk <= 1'b0;
			repeat (FRAME_MIN - 8 * len - 13) @(posedge i_clk_link);
		end
	endtask : frame
endmodule : vcsp_dsp_model

// file: verification/vcsp_top_bench.sv
// Purpose: Self-checking bench for the voice codec serial port
// Assumes: Both formats at fixed rate, linear at variable rate; small frame and detect counts
// Notes: Register bus answers sampled at the rising edge that takes them
`timescale 1ns/1ps
module vcsp_top_bench;
	import vcsp_pkg::*;
	localparam int FB = 8;
	localparam int FD = 16;
	logic clk_sys, clk_link, nrst, avs_read, avs_write, lin_sel, wq, var_rate;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, d, e;
	logic avs_waitrequest, rbcs, tbc, tx_frame_sync, rx_frame_sync, rx_data, tx_data, tx_oe;
	logic [2:0] volume;
	int n_fail, checks_done, seed, vol_m, s, w, len, n;

	vcsp_top #(.FRAME_BITS(FB), .FIXED_DETECT(FD)) dut (.i_clk_sys(clk_sys), .i_nrst(nrst),
		.i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
		.o_avs_waitrequest(avs_waitrequest), .o_volume_setting(volume), .i_clk_link(clk_link),
		.i_rx_bit_clock_select(rbcs), .i_tx_bit_clock(tbc), .i_tx_frame_sync(tx_frame_sync),
		.i_rx_frame_sync(rx_frame_sync), .i_linear_format_select(lin_sel), .i_rx_data(rx_data),
		.o_tx_data(tx_data), .o_tx_data_oe(tx_oe));
	vcsp_dsp_model dsp (.i_clk_link(clk_link), .i_var_rate(var_rate),
		.i_tx_data(tx_data), .i_tx_data_oe(tx_oe),
		.o_rx_bit_clock_select(rbcs), .o_tx_bit_clock(tbc), .o_tx_frame_sync(tx_frame_sync),
		.o_rx_frame_sync(rx_frame_sync), .o_rx_data(rx_data));

	// Clocks; link phase offset keeps the domains unrelated
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 1'b0;
		#3;
		forever #62.5 clk_link = ~clk_link;
	end

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	// Holds the request until the rising edge at which waitrequest is sampled low
	task bus(input logic rd, input logic [3:0] a, input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= rd;
		avs_write <= ~rd;
		n = 0;
		do begin
			@(posedge clk_sys);
			wq = avs_waitrequest;
			d = avs_readdata;
			n++;
		end while (wq !== 1'b0 && n < 200);
		if (n >= 200) begin
			check("bus answer", 0, 1);
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : bus

	// Generic 8-segment law: sign, segment, mantissa
	function automatic int comp_m(input int x);
		int m, seg, man;
		m = x[12] ? (~x & 'hfff) : (x & 'hfff);
		seg = 0;
		man = (m >> 1) & 15;
		for (int i = 1; i < 8; i++) begin
			if ((m >> (i + 4)) & 1) begin
				seg = i;
				man = (m >> i) & 15;
			end
		end
		return (x[12] << 7) | (seg << 4) | man;
	endfunction : comp_m

	function automatic int exp_m(input int c);
		int m;
		m = ((c >> 4) & 7) == 0 ? (c & 15) * 2 + 1 : ((16 + (c & 15)) * 2 + 1) << (((c >> 4) & 7) - 1);
		return c[7] ? ('h1000 | (~m & 'hfff)) : m;
	endfunction : exp_m

	// Pins are static, so they only change under reset
	task do_reset(input int f);
		nrst <= 1'b0;
		lin_sel <= (f == 1);
		var_rate <= (f == 2);
		repeat (8) @(posedge clk_link);
		@(posedge clk_sys);
		nrst <= 1'b1;
		repeat (FD + 6) @(posedge clk_link);
		@(posedge clk_sys);
	endtask : do_reset

	// Watchdog, well beyond the expected run of some 400 us
	initial begin
		#700000;
		n_fail++;
		print_verdict;
	end

	initial begin
		seed = 11;
		nrst = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h00000000;
		lin_sel = 1'b0;
		var_rate = 1'b0;
		for (int f = 0; f < 3; f++) begin
			do_reset(f);
			vol_m = 0;
			len = (f == 1) ? 8 : 16;
			check("volume reset", 0, {29'h0, volume});
			bus(1'b0, VCSP_OFS_STATUS, 32'hffffffff);
			bus(1'b1, VCSP_OFS_STATUS, 0);
			check("status", {30'h0, f != 1, f != 2}, d & 32'h13);
			bus(1'b1, 4'hc, 0);
			check("unmapped read", 0, d);
			repeat (5) begin
				s = $random(seed) & 'h1fff;
				w = $random(seed) & ((f == 1) ? 'hff : 'hffff);
				bus(1'b0, VCSP_OFS_TX_DATA, s);
				do bus(1'b1, VCSP_OFS_STATUS, 0); while (d[4] === 1'b1 && checks_done >= 0);
				dsp.frame(w[15:0], len, $random(seed) & 3);
				e = (f == 1) ? comp_m(s) : s << 3;
				check("tx word", e, {16'h0, dsp.tx_cap} & ((f == 1) ? 'hff : 'hffff));
				check("tx enable misses", 0, dsp.oe_miss);
				n = 0;
				do bus(1'b1, VCSP_OFS_RX_DATA, 0); while (d[31] !== 1'b1 && n < 200);
				if (f != 1) begin
					vol_m = w & 7;
				end
				e = (f == 1) ? exp_m(w) : (w >> 3);
				check("rx data", 32'h80000000 | (vol_m << 16) | e, d);
				check("volume pin", vol_m, {29'h0, volume});
				bus(1'b1, VCSP_OFS_RX_DATA, 0);
				check("rx new flag", 0, {31'h0, d[31]});
			end
			// Standby counts bit events, so only the free-running fixed clock reaches it
			if (f < 2) begin
				repeat (5 * FB + 10) @(posedge clk_link);
				bus(1'b1, VCSP_OFS_STATUS, 0);
				check("standby set", 32'hc, d & 32'hc);
				dsp.frame(16'h0000, len, 0);
				bus(1'b1, VCSP_OFS_STATUS, 0);
				check("standby clear", 0, d & 32'hc);
			end
			$display("format %0d done", f);
		end
		print_verdict;
	end
endmodule : vcsp_top_bench
